// *** verilog/tfpa_pkg.sv ***
package tfpa_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MASK   = 8'h00;
    localparam logic [7:0] OFF_FLAG   = 8'h04;
    localparam logic [7:0] OFF_ACCUM  = 8'h08;
    localparam logic [7:0] OFF_PACNT  = 8'h0C;
    localparam logic [7:0] OFF_EDGE   = 8'h10;
    localparam logic [7:0] OFF_CNT    = 8'h14;
    localparam logic [7:0] OFF_FLAG2  = 8'h18;
    localparam logic [7:0] OFF_MASK2  = 8'h1C;
    localparam logic [7:0] OFF_CMP    = 8'h20;
    localparam logic [7:0] OFF_CAP    = 8'h40;

    // Channel counts
    localparam int NUM_CMP = 5;
    localparam int NUM_CAP = 4;
    localparam int NUM_PIN = 5;

    // Flag and mask bit positions
    localparam int FLG_OC1    = 7;
    localparam int FLG_SHARED = 3;
    localparam int FLG_IC1    = 2;

    // Second status bits
    localparam int FL2_TICK = 0;
    localparam int FL2_POVF = 1;

    // Accumulator control bit positions
    localparam int PAC_DIR7  = 7;
    localparam int PAC_EN    = 6;
    localparam int PAC_MODE  = 5;
    localparam int PAC_EDGE  = 4;
    localparam int PAC_DIR3  = 3;
    localparam int PAC_SEL   = 2;
    localparam int PAC_RATE0 = 0;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Gated accumulation clock divider, in clock cycles
    localparam logic [5:0] GATE_DIV_LAST = 6'h3F;

    // Periodic interrupt base period, in clock cycles
    localparam int unsigned TICK_BASE_DEFAULT = 8192;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tfpa_pkg

// *** verilog/tfpa_top.sv ***
// Summary of operation
// - Compare channel requests interrupt while its enable and compare flag set.
// - Capture channel requests interrupt while its enable and capture flag set.
// - Shared enable serves fourth capture when select is 1, else fifth compare.
// - Each mask bit enables the flag at the same bit position.
// - Writing 1 clears a flag; writing 0 leaves it unchanged.
// - Compare flag sets whenever the free counter equals the compare value.
// - Shared flag set by fourth capture or fifth compare, per select bit.
// - Capture flag sets on each selected active edge of its input.
// - Eight-bit pulse accumulator steered by three control bits.
// - Accumulator runs only when the enable bit is 1.
// - Mode bit 0 counts events; mode bit 1 accumulates gated time.
// - Event mode counts falling edges with edge bit 0, rising with 1.
// - Gated mode inhibits while input equals the edge bit.
// - Select bit 0 enables fifth compare only; 1 enables fourth capture only.
// - Two-bit field selects the periodic interrupt rate.
// - Control register holds port A bit 7 and bit 3 directions.
`timescale 1ns/100ps
module tfpa_top
    import tfpa_pkg::*;
#(
    parameter int unsigned TICK_BASE_CYCLES = TICK_BASE_DEFAULT
) (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    input  logic [3:0]  capture_pins,
    input  logic        accum_input_pin,
    output logic        irq,
    output logic        periodic_interrupt,
    output logic        port_a_bit7_direction,
    output logic        port_a_bit3_direction
);

    typedef struct packed {
        logic [7:0]               aw_addr;
        logic                     aw_got;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     w_got;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic [7:0]               mask;
        logic [7:0]               flag;
        logic [7:0]               acc_ctl;
        logic [7:0]               pacnt;
        logic [7:0]               edge_cfg;
        logic [1:0]               flag2;
        logic [1:0]               mask2;
        logic [15:0]              cnt;
        logic [NUM_CMP-1:0][15:0] cmp;
        logic [NUM_CAP-1:0][15:0] cap;
        logic [5:0]               gdiv;
        logic [19:0]              rdiv;
        logic                     tick_pulse;
        logic [NUM_PIN-1:0]       sync1;
        logic [NUM_PIN-1:0]       sync2;
        logic [NUM_PIN-1:0]       prev;
    } tfpa_state_t;

    tfpa_state_t        state_q;
    tfpa_state_t        state_d;

    logic [NUM_CMP-1:0] cmp_hit;
    logic [NUM_CAP-1:0] cap_hit;
    logic [NUM_PIN-1:0] pin_rise;
    logic [NUM_PIN-1:0] pin_fall;
    logic [7:0]         flag_set;
    logic [7:0]         flag_clr;
    logic [1:0]         flag2_set;
    logic [1:0]         flag2_clr;
    logic               aw_fire;
    logic               w_fire;
    logic               ar_fire;
    logic               wr_go;
    logic [7:0]         wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    logic               wr_ok;
    logic               rd_ok;
    logic [31:0]        rd_word;
    logic               pa_inc;
    logic               tick_hit;
    logic [19:0]        tick_last;
    logic               shared_sel;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic addr_known(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a[1:0] == 2'h0) begin
            if (a < OFF_CMP + 8'(4 * NUM_CMP)) begin
                hit = (a <= OFF_MASK2) || (a >= OFF_CMP);
            end
            if (a >= OFF_CAP && a < OFF_CAP + 8'(4 * NUM_CAP)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : addr_known

    assign shared_sel = state_q.acc_ctl[PAC_SEL];

    // Edge detection on synchronised pins and compare matches
    for (genvar i = 0; i < NUM_PIN; i++) begin : g_ch
        assign pin_rise[i] = state_q.sync2[i] & ~state_q.prev[i];
        assign pin_fall[i] = ~state_q.sync2[i] & state_q.prev[i];
        assign cmp_hit[i] = state_q.cnt == state_q.cmp[i];
        if (i < NUM_CAP) begin : g_cap
            assign cap_hit[i] =
                (state_q.edge_cfg[2*i] & pin_rise[i]) |
                (state_q.edge_cfg[2*i+1] & pin_fall[i]);
        end
    end

    // Handshake outputs
    assign s_axi_awready = ~state_q.aw_got & ~state_q.bvalid;
    assign s_axi_wready  = ~state_q.w_got & ~state_q.bvalid;
    assign s_axi_arready = ~state_q.rvalid;
    assign s_axi_bvalid  = state_q.bvalid;
    assign s_axi_bresp   = state_q.bresp;
    assign s_axi_rvalid  = state_q.rvalid;
    assign s_axi_rdata   = state_q.rdata;
    assign s_axi_rresp   = state_q.rresp;

    assign port_a_bit7_direction = state_q.acc_ctl[PAC_DIR7];
    assign port_a_bit3_direction = state_q.acc_ctl[PAC_DIR3];
    assign periodic_interrupt    = state_q.tick_pulse;

    assign irq = (|(state_q.flag & state_q.mask)) |
                 (|(state_q.flag2 & state_q.mask2));

    always_comb begin
        state_d   = state_q;
        flag_set  = RST_BYTE;
        flag_clr  = RST_BYTE;
        flag2_set = 2'h0;
        flag2_clr = 2'h0;
        wr_go     = 1'b0;
        wr_addr   = state_q.aw_addr;
        wr_data   = state_q.wdata;
        wr_strb   = state_q.wstrb;
        wr_ok     = 1'b0;
        rd_ok     = 1'b0;
        rd_word   = 32'h0000_0000;
        pa_inc    = 1'b0;
        tick_hit  = 1'b0;
        tick_last = 20'h0_0000;
        aw_fire   = s_axi_awvalid & s_axi_awready;
        w_fire    = s_axi_wvalid & s_axi_wready;
        ar_fire   = s_axi_arvalid & s_axi_arready;

        // Pin synchronisers
        state_d.sync1 = {accum_input_pin, capture_pins};
        state_d.sync2 = state_q.sync1;
        state_d.prev  = state_q.sync2;

        // Free-running counter
        state_d.cnt = state_q.cnt + 16'h0001;

        // Write channel collection
        if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end
        if (aw_fire) begin
            state_d.aw_addr = s_axi_awaddr;
            state_d.aw_got  = 1'b1;
        end
        if (w_fire) begin
            state_d.wdata  = s_axi_wdata;
            state_d.wstrb  = s_axi_wstrb;
            state_d.w_got  = 1'b1;
        end
        if (state_d.aw_got && state_d.w_got) begin
            wr_go          = 1'b1;
            wr_addr        = state_d.aw_addr;
            wr_data        = state_d.wdata;
            wr_strb        = state_d.wstrb;
            wr_ok          = addr_known(state_d.aw_addr);
            state_d.aw_got = 1'b0;
            state_d.w_got  = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // Flag clear strobes
        if (wr_go && wr_strb[0]) begin
            if (wr_addr == OFF_FLAG) begin
                flag_clr = wr_data[7:0];
            end
            if (wr_addr == OFF_FLAG2) begin
                flag2_clr = wr_data[1:0];
            end
        end

        // Timer flag sources
        for (int i = 0; i < 4; i++) begin
            flag_set[FLG_OC1-i] = cmp_hit[i];
        end
        for (int i = 0; i < 3; i++) begin
            flag_set[FLG_IC1-i] = cap_hit[i];
        end
        flag_set[FLG_SHARED] = shared_sel ? cap_hit[NUM_CAP-1]
                                          : cmp_hit[NUM_CMP-1];

        // Capture latches
        for (int i = 0; i < NUM_CAP - 1; i++) begin
            if (cap_hit[i]) begin
                state_d.cap[i] = state_q.cnt;
            end
        end
        if (shared_sel && cap_hit[NUM_CAP-1]) begin
            state_d.cap[NUM_CAP-1] = state_q.cnt;
        end

        if (state_q.acc_ctl[PAC_EN]) begin
            if (!state_q.acc_ctl[PAC_MODE]) begin
                pa_inc = state_q.acc_ctl[PAC_EDGE] ? pin_rise[NUM_PIN-1]
                                                   : pin_fall[NUM_PIN-1];
                state_d.gdiv = 6'h00;
            end else begin
                state_d.gdiv = state_q.gdiv + 6'h01;
                if (state_q.gdiv == GATE_DIV_LAST) begin
                    state_d.gdiv = 6'h00;
                    pa_inc = state_q.sync2[NUM_PIN-1] !=
                             state_q.acc_ctl[PAC_EDGE];
                end
            end
        end else begin
            state_d.gdiv = 6'h00;
        end
        if (pa_inc) begin
            state_d.pacnt = state_q.pacnt + 8'h01;
            if (state_q.pacnt == 8'hFF) begin
                flag2_set[FL2_POVF] = 1'b1;
            end
        end

        tick_last = 20'((TICK_BASE_CYCLES <<
                    state_q.acc_ctl[PAC_RATE0 +: 2]) - 1);
        if (state_q.rdiv >= tick_last) begin
            tick_hit     = 1'b1;
            state_d.rdiv = 20'h0_0000;
        end else begin
            state_d.rdiv = state_q.rdiv + 20'h0_0001;
        end
        state_d.tick_pulse  = tick_hit;
        flag2_set[FL2_TICK] = tick_hit;

        state_d.flag  = (state_q.flag & ~flag_clr) | flag_set;
        state_d.flag2 = (state_q.flag2 & ~flag2_clr) | flag2_set;

        // Register writes
        if (wr_go && wr_ok) begin
            case (wr_addr)
                OFF_MASK: begin
                    state_d.mask = 8'(merge_bytes(32'(state_q.mask),
                                   wr_data, wr_strb));
                end
                OFF_ACCUM: begin
                    state_d.acc_ctl = 8'(merge_bytes(32'(state_q.acc_ctl),
                                      wr_data, wr_strb));
                end
                OFF_PACNT: begin
                    state_d.pacnt = 8'(merge_bytes(32'(state_d.pacnt),
                                    wr_data, wr_strb));
                end
                OFF_EDGE: begin
                    state_d.edge_cfg = 8'(merge_bytes(
                        32'(state_q.edge_cfg), wr_data, wr_strb));
                end
                OFF_MASK2: begin
                    state_d.mask2 = 2'(merge_bytes(32'(state_q.mask2),
                                    wr_data, wr_strb));
                end
                default: begin
                    for (int i = 0; i < NUM_CMP; i++) begin
                        if (wr_addr == OFF_CMP + 8'(4 * i)) begin
                            state_d.cmp[i] = 16'(merge_bytes(
                                32'(state_q.cmp[i]), wr_data,
                                wr_strb));
                        end
                    end
                end
            endcase
        end

        // Read channel
        if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
        if (ar_fire) begin
            rd_ok = addr_known(s_axi_araddr);
            case (s_axi_araddr)
                OFF_MASK:  rd_word = {24'h00_0000, state_q.mask};
                OFF_FLAG:  rd_word = {24'h00_0000, state_q.flag};
                OFF_ACCUM: rd_word = {24'h00_0000, state_q.acc_ctl};
                OFF_PACNT: rd_word = {24'h00_0000, state_q.pacnt};
                OFF_EDGE:  rd_word = {24'h00_0000, state_q.edge_cfg};
                OFF_CNT:   rd_word = {16'h0000, state_q.cnt};
                OFF_FLAG2: rd_word = {30'h0000_0000, state_q.flag2};
                OFF_MASK2: rd_word = {30'h0000_0000, state_q.mask2};
                default: begin
                    for (int i = 0; i < NUM_CMP; i++) begin
                        if (s_axi_araddr == OFF_CMP + 8'(4 * i)) begin
                            rd_word = {16'h0000, state_q.cmp[i]};
                        end
                    end
                    for (int i = 0; i < NUM_CAP; i++) begin
                        if (s_axi_araddr == OFF_CAP + 8'(4 * i)) begin
                            rd_word = {16'h0000, state_q.cap[i]};
                        end
                    end
                end
            endcase
            state_d.rvalid = 1'b1;
            state_d.rdata  = rd_ok ? rd_word : 32'h0000_0000;
            state_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : tfpa_top

// *** testbench/tfpa_properties.sv ***
`timescale 1ns/100ps
module tfpa_properties
    import tfpa_pkg::*;
(
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        irq,
    input logic        periodic_interrupt,
    input logic        port_a_bit7_direction,
    input logic        port_a_bit3_direction
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    write_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not refused");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    write_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    reset_state_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid
        && !s_axi_rvalid && !port_a_bit7_direction) else $error("reset state");
    dir_change_a: assert property (($changed(port_a_bit7_direction) ||
        $changed(port_a_bit3_direction)) && $past(aresetn) |-> s_axi_bvalid)
        else $error("direction changed without write");
    irq_release_a: assert property ($fell(irq) && $past(aresetn)
        |-> s_axi_bvalid) else $error("irq dropped without write");
    rate_pulse_a: assert property (periodic_interrupt
        |=> !periodic_interrupt) else $error("periodic pulse too long");

    cover property ($rose(irq));
    cover property (periodic_interrupt);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : tfpa_properties

bind tfpa_top tfpa_properties u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .periodic_interrupt(periodic_interrupt),
    .port_a_bit7_direction(port_a_bit7_direction),
    .port_a_bit3_direction(port_a_bit3_direction));

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
    import tfpa_pkg::*;
    localparam int unsigned BASE = 16;
    logic        aclk = 1'h0, aresetn = 1'h0, acc_pin = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  cap = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        irq, tick, dir7, dir3;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int          mismatches = 0, check_count = 0;

    always #5 aclk = ~aclk;

    tfpa_top #(.TICK_BASE_CYCLES(BASE)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_pins(cap), .accum_input_pin(acc_pin),
        .irq(irq), .periodic_interrupt(tick), .port_a_bit7_direction(dir7),
        .port_a_bit3_direction(dir3));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (n++ > 50) begin
                mismatches++;
                tally_and_finish();
            end
        end while (!bvalid);
        rs = bresp;
        bready <= 1'h0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (n++ > 50) begin
                mismatches++;
                tally_and_finish();
            end
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : rdr

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge aclk) acc_pin <= 1'h1;
            repeat (4) @(posedge aclk);
            acc_pin <= 1'h0;
            repeat (4) @(posedge aclk);
        end
    endtask : pulse

    function automatic int flag_pos(input int i, input int last);
        return (i < last) ? FLG_OC1 - i - (last == 3 ? 5 : 0) : FLG_SHARED;
    endfunction : flag_pos

    function automatic logic [31:0] acc_exp(input int n, input bit en);
        return en ? 32'(8'(8'hFE + n)) : 32'hFE;
    endfunction : acc_exp

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        int i, n, c;
        logic [7:0] m;
        void'($urandom(32'h2914));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 3; i++) begin
            rdr(8'(4 * i));
            chk(rd, (i == 1) ? 32'hF8 : 32'h0);
        end
        m = 8'($urandom);
        wr(OFF_MASK, {24'hFFFFFF, m});
        rdr(OFF_MASK);
        chk(rd, 32'(m));
        wr(OFF_ACCUM, 32'(m));
        chk(32'({dir7, dir3}), 32'({m[PAC_DIR7], m[PAC_DIR3]}));
        rdr(OFF_ACCUM);
        chk(rd, 32'(m));
        wr(8'h34, 32'h1);
        chk(32'(rs), 32'(RESP_SLVERR));
        rdr(8'h34);
        chk(rd, 32'h0);
        chk(32'(rs), 32'(RESP_SLVERR));
        wr(OFF_ACCUM, 32'h0);
        wr(OFF_MASK, 32'h0);
        $display("test registers done");
        for (i = 0; i < NUM_CMP; i++) begin
            rdr(OFF_CNT);
            wr(OFF_CMP + 8'(4 * i), 32'(16'(rd[15:0] + 16'h28)));
            wr(OFF_FLAG, 32'h1 << flag_pos(i, 4));
            repeat (50) @(posedge aclk);
            rdr(OFF_FLAG);
            chk(32'(rd[flag_pos(i, 4)]), 32'h1);
        end
        chk(32'(irq), 32'h0);
        wr(OFF_FLAG, 32'h0);
        rdr(OFF_FLAG);
        chk(rd, 32'hF8);
        m = 8'($urandom);
        wr(OFF_MASK, 32'(m));
        chk(32'(irq), 32'(|(m & 8'hF8)));
        wr(OFF_FLAG, 32'hFF);
        chk(32'(irq), 32'h0);
        rdr(OFF_FLAG);
        chk(rd, 32'h0);
        $display("test compare done");
        wr(OFF_MASK, 32'hFF);
        for (i = 0; i < NUM_CAP; i++) begin
            wr(OFF_ACCUM, 32'(i == 3) << PAC_SEL);
            wr(OFF_EDGE, 32'h1 << (2 * i));
            @(posedge aclk) cap[i] <= 1'h1;
            repeat (8) @(posedge aclk);
            rdr(OFF_FLAG);
            chk(rd, 32'h1 << flag_pos(i, 3));
            chk(32'(irq), 32'h1);
            wr(OFF_FLAG, 32'hFF);
            @(posedge aclk) cap[i] <= 1'h0;
            repeat (8) @(posedge aclk);
            rdr(OFF_FLAG);
            chk(rd, 32'h0);
        end
        wr(OFF_ACCUM, 32'h0);
        wr(OFF_EDGE, 32'hC0);
        @(posedge aclk) cap[3] <= 1'h1;
        repeat (8) @(posedge aclk);
        rdr(OFF_FLAG);
        chk(rd, 32'h0);
        $display("test capture done");
        for (i = 0; i < 3; i++) begin
            n = $urandom_range(6, 1);
            wr(OFF_PACNT, 32'hFE);
            wr(OFF_FLAG2, 32'hFF);
            wr(OFF_ACCUM, 32'(i < 2) << PAC_EN | 32'(i % 2) << PAC_EDGE);
            pulse(n);
            rdr(OFF_PACNT);
            chk(rd, acc_exp(n, i < 2));
            rdr(OFF_FLAG2);
            chk(32'(rd[FL2_POVF]), 32'(i < 2 && n > 1));
        end
        for (i = 0; i < 2; i++) begin
            @(posedge aclk) acc_pin <= (i == 0);
            wr(OFF_PACNT, 32'h0);
            wr(OFF_ACCUM, 32'h60 | 32'(i) << PAC_EDGE);
            repeat (256) @(posedge aclk);
            rdr(OFF_PACNT);
            chk(32'(rd >= 3 && rd <= 5), 32'h1);
            @(posedge aclk) acc_pin <= (i == 1);
            repeat (8) @(posedge aclk);
            rdr(OFF_PACNT);
            c = int'(rd);
            repeat (200) @(posedge aclk);
            rdr(OFF_PACNT);
            chk(rd, 32'(c));
        end
        $display("test accumulator done");
        wr(OFF_MASK2, 32'h1);
        for (i = 0; i < 4; i++) begin
            wr(OFF_ACCUM, 32'(i));
            wr(OFF_FLAG2, 32'hFF);
            c = 0;
            repeat (512) @(posedge aclk) c += int'(tick);
            n = 512 / (BASE << i);
            chk(32'(c >= n - 1 && c <= n + 1), 32'h1);
            chk(32'(irq), 32'h1);
        end
        $display("test periodic done");
        tally_and_finish();
    end
endmodule : tb
